// ### design/pbtm_pkg.sv
// Package for the paired 8-bit timer block: register map, fields, codes and reset values
package pbtm_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int PRE_W  = 9;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_RUN     = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CMP_LO  = 8'h02;
	localparam logic [ADDR_W-1:0] OFS_CMP_HI  = 8'h03;
	localparam logic [ADDR_W-1:0] OFS_MODE    = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_TOGGLE  = 8'h05;
	localparam logic [ADDR_W-1:0] OFS_CNT_LO  = 8'h06;
	localparam logic [ADDR_W-1:0] OFS_CNT_HI  = 8'h07;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int RUN_LO_BIT   = 0;
	localparam int RUN_HI_BIT   = 1;
	localparam int RUN_PRE_BIT  = 2;
	localparam int RUN_IDLE_BIT = 3;
	localparam int RUN_DBE_BIT  = 7;
	localparam int MODE_LSB     = 6;
	localparam int PWM_LSB      = 4;
	localparam int HCLK_LSB     = 2;
	localparam int LCLK_LSB     = 0;
	localparam int TG_SEL_BIT   = 0;
	localparam int TG_IE_BIT    = 1;
	localparam int TG_CMD_LSB   = 2;

	// Prescaler tap bit for each tick rate
	localparam int TAP_T1   = 0;
	localparam int TAP_T4   = 2;
	localparam int TAP_T16  = 4;
	localparam int TAP_T256 = 8;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
	localparam logic [PRE_W-1:0]  RST_PRE  = 9'h000;

	// ------------------------------------------------------------
	// Codes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PBTM_DUAL8 = 2'b00,
		PBTM_CAS16 = 2'b01,
		PBTM_PPG   = 2'b10,
		PBTM_PWM   = 2'b11
	} pbtm_mode_t;

	localparam logic [1:0] PWM_P6 = 2'b01;
	localparam logic [1:0] PWM_P7 = 2'b10;
	localparam logic [1:0] PWM_P8 = 2'b11;

	localparam logic [1:0] CLK_SEL0 = 2'b00;
	localparam logic [1:0] CLK_SEL1 = 2'b01;
	localparam logic [1:0] CLK_SEL2 = 2'b10;

	localparam logic [1:0] TG_INVERT = 2'b00;
	localparam logic [1:0] TG_SET    = 2'b01;
	localparam logic [1:0] TG_CLEAR  = 2'b10;

	// ------------------------------------------------------------
	// Register bus request
	// ------------------------------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              we;
		logic              re;
	} pbtm_bus_req_t;

endpackage

// ### design/pbtm_timer_pair.sv
// Paired 8-bit timer with dual, cascaded, pulse-generator and PWM modes
//
// Operation
// - Run register bits four to six read zero
// - Run register holds idle, prescaler, timer runs
// - Clearing run bit stops, zeroes counter
// - Lower clock: external pin or three taps
// - Upper clock: lower match or three taps; in PWM mode the lower match setting gives no clock
// - Toggle flip-flop drives timer output pin
// - Toggle control clears and enables inversion
// - Mode 01 joins timers into sixteen bits
// - Cascade: upper clocked by lower overflow
// - Cascade: lower match pulses, no clear
// - Cascade full match clears both, interrupts
// - Pulse mode toggles on either compare
// - Pulse polarity chosen by toggle preset
// - Pulse mode reloads buffer on upper match
// - PWM on lower timer, upper stays timer
// - PWM toggles on match and period overflow
// - PWM reloads buffer on period overflow
// - PWM period two to six, seven, eight
// - Mode and period field encodings fixed
// - Buffered writes skip the compare register
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps

module pbtm_timer_pair (
	input  wire logic                          clk,
	input  wire logic                          arst_n,
	input  wire pbtm_pkg::pbtm_bus_req_t       bus_req,
	output logic      [pbtm_pkg::DATA_W-1:0]   bus_rdata_q,
	input  wire logic                          ext_count_clock_pin,
	input  wire logic                          light_sleep_state,
	output logic                               timer_out_pin,
	output logic                               lower_match_irq,
	output logic                               upper_match_irq
);
	import pbtm_pkg::*;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [DATA_W-1:0] run_q;
	logic [DATA_W-1:0] mode_q;
	logic [1:0]        tg_ctl_q;
	logic [DATA_W-1:0] cmp_lo_q;
	logic [DATA_W-1:0] cmp_lo_buf_q;
	logic [DATA_W-1:0] cmp_hi_q;
	logic [DATA_W-1:0] cnt_lo_q;
	logic [DATA_W-1:0] cnt_hi_q;
	logic [PRE_W-1:0]  pre_q;
	logic              ff_q;
	logic              ext_s1_q;
	logic              ext_s2_q;
	logic              ext_s3_q;
	logic              ext_lvl_q;
	logic              lo_irq_q;
	logic              hi_irq_q;

	logic              wr_run;
	logic              wr_mode;
	logic              wr_tg;
	logic              wr_cmp_lo;
	logic              wr_cmp_hi;
	pbtm_mode_t        mode;
	logic [1:0]        pwm_sel;
	logic [1:0]        hclk_sel;
	logic [1:0]        lclk_sel;
	logic              dbe;
	logic              run_lo;
	logic              run_hi;
	logic              pre_run;
	logic              halt;
	logic              tick_t1;
	logic              tick_t4;
	logic              tick_t16;
	logic              tick_t256;
	logic              ext_rise;
	logic              tick_lo;
	logic              tick_hi;
	logic [DATA_W-1:0] lo_inc;
	logic [DATA_W-1:0] hi_inc;
	logic              lo_match;
	logic              hi_match_ppg;
	logic              lo_ovf;
	logic              pwm_ovf;
	logic              full16;
	logic              hi_match;
	logic              dual_toggle;
	logic              toggle_ev;
	logic              db_load;

	// Register field views
	assign mode     = pbtm_mode_t'(mode_q[MODE_LSB +: 2]);
	assign pwm_sel  = mode_q[PWM_LSB +: 2];
	assign hclk_sel = mode_q[HCLK_LSB +: 2];
	assign lclk_sel = mode_q[LCLK_LSB +: 2];
	assign dbe      = run_q[RUN_DBE_BIT];
	assign run_lo   = run_q[RUN_LO_BIT];
	assign run_hi   = run_q[RUN_HI_BIT];
	// Light sleep without the operate bit freezes the whole pair
	assign halt     = light_sleep_state & ~run_q[RUN_IDLE_BIT];
	assign pre_run  = run_q[RUN_PRE_BIT] & ~halt;

	// Write decode
	always_comb begin
		wr_run    = 1'b0;
		wr_mode   = 1'b0;
		wr_tg     = 1'b0;
		wr_cmp_lo = 1'b0;
		wr_cmp_hi = 1'b0;
		if (bus_req.we && bus_req.addr == OFS_RUN) begin
			wr_run = 1'b1;
		end else if (bus_req.we && bus_req.addr == OFS_MODE) begin
			wr_mode = 1'b1;
		end else if (bus_req.we && bus_req.addr == OFS_TOGGLE) begin
			wr_tg = 1'b1;
		end else if (bus_req.we && bus_req.addr == OFS_CMP_LO) begin
			wr_cmp_lo = 1'b1;
		end else if (bus_req.we && bus_req.addr == OFS_CMP_HI) begin
			wr_cmp_hi = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	// run register storage; buffering resets disabled
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			run_q <= RST_BYTE;
		end else if (wr_run) begin
			run_q <= bus_req.wdata & 8'h8f;
		end
	end

	// Mode, clock selects and PWM period
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_q <= RST_BYTE;
		end else if (wr_mode) begin
			mode_q <= bus_req.wdata;
		end
	end

	// Toggle enable and source select
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tg_ctl_q <= 2'b00;
		end else if (wr_tg) begin
			tg_ctl_q <= bus_req.wdata[TG_IE_BIT:TG_SEL_BIT];
		end
	end

	// write always lands in the buffer
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cmp_lo_buf_q <= RST_BYTE;
		end else if (wr_cmp_lo) begin
			cmp_lo_buf_q <= bus_req.wdata;
		end
	end

	// direct write only when unbuffered; reload on event
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cmp_lo_q <= RST_BYTE;
		end else if (wr_cmp_lo && !dbe) begin
			cmp_lo_q <= bus_req.wdata;
		end else if (db_load && dbe) begin
			cmp_lo_q <= cmp_lo_buf_q;
		end
	end

	// Upper compare register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cmp_hi_q <= RST_BYTE;
		end else if (wr_cmp_hi) begin
			cmp_hi_q <= bus_req.wdata;
		end
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	// bits four to six read zero; compares read zero
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bus_rdata_q <= RST_BYTE;
		end else if (!bus_req.re) begin
			bus_rdata_q <= RST_BYTE;
		end else if (bus_req.addr == OFS_RUN) begin
			bus_rdata_q <= run_q & 8'h8f;
		end else if (bus_req.addr == OFS_MODE) begin
			bus_rdata_q <= mode_q;
		end else if (bus_req.addr == OFS_TOGGLE) begin
			bus_rdata_q <= {ff_q, 5'h00, tg_ctl_q};
		end else if (bus_req.addr == OFS_CNT_LO) begin
			bus_rdata_q <= cnt_lo_q;
		end else if (bus_req.addr == OFS_CNT_HI) begin
			bus_rdata_q <= cnt_hi_q;
		end else begin
			bus_rdata_q <= RST_BYTE;
		end
	end

	// ------------------------------------------------------------
	// Prescaler and external clock
	// ------------------------------------------------------------
	// Free counter, held at zero while stopped
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pre_q <= RST_PRE;
		end else if (!run_q[RUN_PRE_BIT]) begin
			pre_q <= RST_PRE;
		end else if (pre_run) begin
			pre_q <= pre_q + 9'h001;
		end
	end

	// Tap ticks fire when all bits below and at the tap are ones
	assign tick_t1   = pre_run & (&pre_q[TAP_T1:0]);
	assign tick_t4   = pre_run & (&pre_q[TAP_T4:0]);
	assign tick_t16  = pre_run & (&pre_q[TAP_T16:0]);
	assign tick_t256 = pre_run & (&pre_q[TAP_T256:0]);

	// Pin synchroniser; level follows once stages two and three agree
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ext_s1_q  <= 1'b0;
			ext_s2_q  <= 1'b0;
			ext_s3_q  <= 1'b0;
			ext_lvl_q <= 1'b0;
		end else begin
			ext_s1_q <= ext_count_clock_pin;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
			if (ext_s2_q == ext_s3_q) begin
				ext_lvl_q <= ext_s3_q;
			end
		end
	end

	assign ext_rise = ext_s2_q & ext_s3_q & ~ext_lvl_q & ~halt;

	// lower clock choice: pin, T1, T4, T16
	always_comb begin
		case (lclk_sel)
			CLK_SEL0: tick_lo = ext_rise;
			CLK_SEL1: tick_lo = tick_t1;
			CLK_SEL2: tick_lo = tick_t4;
			default:  tick_lo = tick_t16;
		endcase
		tick_lo = tick_lo & run_lo;
	end

	// ------------------------------------------------------------
	// Match logic
	// ------------------------------------------------------------
	assign lo_inc = cnt_lo_q + 8'h01;
	assign hi_inc = cnt_hi_q + 8'h01;
	// Compare value zero matches on wrap, a period of 256 ticks
	assign lo_match     = tick_lo & (lo_inc == cmp_lo_q);
	assign hi_match_ppg = tick_lo & (lo_inc == cmp_hi_q);
	assign lo_ovf       = tick_lo & (cnt_lo_q == 8'hff);

	// period end at 2^6, 2^7 or 2^8 ticks
	always_comb begin
		case (pwm_sel)
			PWM_P6:  pwm_ovf = tick_lo & (cnt_lo_q[5:0] == 6'h3f);
			PWM_P7:  pwm_ovf = tick_lo & (cnt_lo_q[6:0] == 7'h7f);
			PWM_P8:  pwm_ovf = lo_ovf;
			default: pwm_ovf = 1'b0;
		endcase
	end

	// both halves equal their compares together
	assign full16 = (mode == PBTM_CAS16) & lo_match & (cnt_hi_q == cmp_hi_q);

	always_comb begin
		tick_hi = 1'b0;
		case (mode)
			PBTM_DUAL8: begin
				case (hclk_sel)
					CLK_SEL0: tick_hi = lo_match;
					CLK_SEL1: tick_hi = tick_t1;
					CLK_SEL2: tick_hi = tick_t16;
					default:  tick_hi = tick_t256;
				endcase
			end
			PBTM_CAS16: tick_hi = lo_ovf;
			PBTM_PWM: begin
				case (hclk_sel)
					CLK_SEL1: tick_hi = tick_t1;
					CLK_SEL2: tick_hi = tick_t16;
					CLK_SEL0: tick_hi = 1'b0;
					default:  tick_hi = tick_t256;
				endcase
			end
			default: tick_hi = 1'b0;
		endcase
		tick_hi = tick_hi & run_hi;
	end

	assign hi_match = tick_hi & (hi_inc == cmp_hi_q);

	// ------------------------------------------------------------
	// Up counters
	// ------------------------------------------------------------
	// stop clears lower counter
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_lo_q <= RST_BYTE;
		end else if (!run_lo) begin
			cnt_lo_q <= RST_BYTE;
		end else if (tick_lo) begin
			case (mode)
				PBTM_DUAL8: cnt_lo_q <= lo_match ? RST_BYTE : lo_inc;
				PBTM_CAS16: cnt_lo_q <= full16 ? RST_BYTE : lo_inc;
				// upper compare ends the pulse period
				PBTM_PPG:   cnt_lo_q <= hi_match_ppg ? RST_BYTE : lo_inc;
				default:    cnt_lo_q <= pwm_ovf ? RST_BYTE : lo_inc;
			endcase
		end
	end

	// stop clears upper counter; cascade half
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_hi_q <= RST_BYTE;
		end else if (!run_hi || full16 || mode == PBTM_PPG) begin
			cnt_hi_q <= RST_BYTE;
		end else if (tick_hi) begin
			cnt_hi_q <= (hi_match && mode != PBTM_CAS16) ? RST_BYTE : hi_inc;
		end
	end

	// ------------------------------------------------------------
	// Toggle flip-flop and events
	// ------------------------------------------------------------
	// PWM inverts on match and period end; pulse mode on either compare
	always_comb begin
		dual_toggle = tg_ctl_q[TG_SEL_BIT] ? hi_match : lo_match;
		case (mode)
			PBTM_DUAL8: toggle_ev = dual_toggle;
			PBTM_CAS16: toggle_ev = full16;
			PBTM_PPG:   toggle_ev = lo_match | hi_match_ppg;
			default:    toggle_ev = lo_match | pwm_ovf;
		endcase
	end

	assign db_load = (mode == PBTM_PPG) ? hi_match_ppg : ((mode == PBTM_PWM) & pwm_ovf);

	// software preset wins over an inversion in the same cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ff_q <= 1'b0;
		end else if (wr_tg && bus_req.wdata[TG_CMD_LSB +: 2] == TG_CLEAR) begin
			ff_q <= 1'b0;
		end else if (wr_tg && bus_req.wdata[TG_CMD_LSB +: 2] == TG_SET) begin
			ff_q <= 1'b1;
		end else if (wr_tg && bus_req.wdata[TG_CMD_LSB +: 2] == TG_INVERT) begin
			ff_q <= ~ff_q;
		end else if (toggle_ev && tg_ctl_q[TG_IE_BIT]) begin
			ff_q <= ~ff_q;
		end
	end

	assign timer_out_pin = ff_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lo_irq_q <= 1'b0;
			hi_irq_q <= 1'b0;
		end else begin
			lo_irq_q <= lo_match & (mode != PBTM_PPG);
			hi_irq_q <= (mode == PBTM_CAS16) ? full16 : ((mode == PBTM_PPG) ? hi_match_ppg : hi_match);
		end
	end

	assign lower_match_irq = lo_irq_q;
	assign upper_match_irq = hi_irq_q;

endmodule // pbtm_timer_pair

// ### verification/pbtm_assertions.sv
// Port checker for the paired 8-bit timer
`timescale 1ns/1ps

module pbtm_assertions (
	input wire logic                        clk,
	input wire logic                        arst_n,
	input wire pbtm_pkg::pbtm_bus_req_t     bus_req,
	input wire logic [pbtm_pkg::DATA_W-1:0] bus_rdata_q,
	input wire logic                        timer_out_pin,
	input wire logic                        lower_match_irq,
	input wire logic                        upper_match_irq
);
	import pbtm_pkg::*;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	// ---
	// Access steps
	// ---
	sequence s_wr(logic [7:0] a);
		bus_req.we && bus_req.addr == a;
	endsequence
	sequence s_rd(logic [7:0] a);
		bus_req.re && bus_req.addr == a;
	endsequence
	sequence s_stop;
		bus_req.we && bus_req.addr == OFS_RUN && !bus_req.wdata[RUN_LO_BIT];
	endsequence

	chk_run_readback:
		assert property (s_wr(OFS_RUN) ##2 s_rd(OFS_RUN) |=> bus_rdata_q == ($past(bus_req.wdata, 3) & 8'h8f))
		else $error("run register readback wrong");
	chk_run_gap:
		assert property (s_rd(OFS_RUN) |=> bus_rdata_q[6:4] == 3'b000)
		else $error("run register bits 6..4 not zero");
	chk_mode_readback:
		assert property (s_wr(OFS_MODE) ##2 s_rd(OFS_MODE) |=> bus_rdata_q == $past(bus_req.wdata, 3))
		else $error("mode register readback wrong");
	chk_cmp_hidden:
		assert property (bus_req.re && (bus_req.addr == OFS_CMP_LO || bus_req.addr == OFS_CMP_HI) |=> bus_rdata_q == 8'h00)
		else $error("compare register readable");
	chk_stop_zero:
		assert property (s_stop ##2 s_rd(OFS_CNT_LO) |=> bus_rdata_q == 8'h00)
		else $error("stopped counter not zero");
	chk_ff_readback:
		assert property (s_rd(OFS_TOGGLE) |=> bus_rdata_q[7] == $past(timer_out_pin))
		else $error("output pin differs from flip-flop");
	chk_ff_clear:
		assert property (s_wr(OFS_TOGGLE) ##0 bus_req.wdata[3:2] == TG_CLEAR |=> !timer_out_pin)
		else $error("clear command ignored");
	chk_ff_set:
		assert property (s_wr(OFS_TOGGLE) ##0 bus_req.wdata[3:2] == TG_SET |=> timer_out_pin)
		else $error("set command ignored");
	chk_lo_pulse:
		assert property (lower_match_irq |=> !lower_match_irq)
		else $error("lower request longer than a cycle");
	chk_hi_pulse:
		assert property ($rose(upper_match_irq) |=> $fell(upper_match_irq))
		else $error("upper request longer than a cycle");
endmodule // pbtm_assertions

// ### verification/tb_top.sv
// Self-checking bench for the paired 8-bit timer
`timescale 1ns/1ps

module tb_top;
	import pbtm_pkg::*;

	logic              clk;
	logic              arst_n;
	pbtm_bus_req_t     bus_req;
	logic [DATA_W-1:0] bus_rdata_q;
	logic              ext_count_clock_pin;
	logic              light_sleep_state;
	logic              timer_out_pin;
	logic              lower_match_irq;
	logic              upper_match_irq;
	int                miscompares;
	int                check_count;
	int                per;
	int                hi;
	int                lclk [4] = '{24, 6, 24, 96};
	int                hclk [4] = '{12, 4, 64, 1024};

	pbtm_timer_pair i_dut (
		.clk                 (clk),
		.arst_n              (arst_n),
		.bus_req             (bus_req),
		.bus_rdata_q         (bus_rdata_q),
		.ext_count_clock_pin (ext_count_clock_pin),
		.light_sleep_state   (light_sleep_state),
		.timer_out_pin       (timer_out_pin),
		.lower_match_irq     (lower_match_irq),
		.upper_match_irq     (upper_match_irq)
	);

	// ---
	// Clocks
	// ---
	// System clock, 50 ns
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// External count clock, one rise every 8 cycles, changed just after a rising edge
	initial begin
		ext_count_clock_pin = 1'b0;
		forever begin
			repeat (4) @(posedge clk);
			ext_count_clock_pin <= ~ext_count_clock_pin;
		end
	end

	// ---
	// Tasks
	// ---
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
		@(posedge clk);
		bus_req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
		@(posedge clk);
		bus_req <= '0;
		@(negedge clk);
		chk(bus_rdata_q, exp);
	endtask
	function automatic logic sig(input int s);
		case (s)
			0: return lower_match_irq;
			1: return upper_match_irq;
			default: return timer_out_pin;
		endcase
	endfunction
	// Rise-to-rise span and high span of a watched output, bounded
	task automatic meas(input int s);
		int n;
		n = 0;
		per = 0;
		hi = 0;
		while (sig(s) !== 1'b0 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		while (sig(s) !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		while (sig(s) === 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
			hi++;
		end
		while (sig(s) !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
			per++;
		end
		per += hi;
		// A watch that runs out of cycles counts as a mismatch
		if (n >= 3000) begin
			miscompares++;
		end
	endtask
	task automatic finish_test();
		if (miscompares == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ---
	// Tests
	// ---
	initial begin
		bus_req = '0;
		arst_n = 1'b0;
		light_sleep_state = 1'b0;
		miscompares = 0;
		check_count = 0;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		rd(OFS_RUN, 8'h00);
		rd(OFS_MODE, 8'h00);
		wr(OFS_RUN, 8'hff);
		rd(OFS_RUN, 8'h8f);
		wr(OFS_RUN, 8'h00);
		wr(OFS_CMP_LO, 8'h03);
		rd(OFS_CMP_LO, 8'h00);
		wr(OFS_TOGGLE, 8'h06);
		rd(OFS_TOGGLE, 8'h82);
		wr(OFS_TOGGLE, 8'h02);
		rd(OFS_TOGGLE, 8'h02);
		wr(OFS_TOGGLE, 8'h0e);
		rd(OFS_TOGGLE, 8'h02);
		for (int i = 0; i < 4; i++) begin
			wr(OFS_RUN, 8'h00);
			wr(OFS_MODE, {6'h00, i[1:0]});
			wr(OFS_RUN, 8'h05);
			meas(0);
			chk(per, lclk[i]);
		end
		wr(OFS_CMP_HI, 8'h02);
		for (int i = 0; i < 4; i++) begin
			wr(OFS_RUN, 8'h00);
			wr(OFS_MODE, {4'h0, i[1:0], 2'b01});
			rd(OFS_MODE, {4'h0, i[1:0], 2'b01});
			wr(OFS_RUN, 8'h07);
			meas(1);
			chk(per, hclk[i]);
		end
		wr(OFS_TOGGLE, 8'h0a);
		meas(2);
		chk(per, 12);
		chk(hi, 6);
		// Upper matches as toggle source, upper clock T1
		wr(OFS_MODE, 8'h05);
		wr(OFS_TOGGLE, 8'h0b);
		meas(2);
		chk(per, 8);
		wr(OFS_RUN, 8'h87);
		wr(OFS_CMP_LO, 8'h05);
		meas(0);
		chk(per, 6);
		wr(OFS_RUN, 8'h07);
		wr(OFS_CMP_LO, 8'h05);
		meas(0);
		chk(per, 10);
		wr(OFS_RUN, 8'h00);
		rd(OFS_CNT_LO, 8'h00);
		// cascaded pair, upper clock field ignored
		wr(OFS_CMP_LO, 8'h02);
		wr(OFS_CMP_HI, 8'h01);
		wr(OFS_MODE, 8'h4d);
		wr(OFS_RUN, 8'h07);
		meas(1);
		chk(per, 516);
		wr(OFS_RUN, 8'h00);
		wr(OFS_CMP_LO, 8'h01);
		wr(OFS_CMP_HI, 8'h04);
		wr(OFS_MODE, 8'h81);
		wr(OFS_TOGGLE, 8'h06);
		wr(OFS_RUN, 8'h87);
		meas(2);
		chk(per, 8);
		chk(hi, 2);
		wr(OFS_CMP_LO, 8'h03);
		meas(1);
		meas(2);
		chk(hi, 6);
		wr(OFS_RUN, 8'h00);
		wr(OFS_CMP_LO, 8'h10);
		wr(OFS_CMP_HI, 8'h03);
		for (int p = 1; p < 4; p++) begin
			wr(OFS_RUN, 8'h00);
			wr(OFS_TOGGLE, 8'h0a);
			wr(OFS_MODE, {2'b11, p[1:0], 4'b0101});
			wr(OFS_RUN, 8'h07);
			meas(2);
			chk(per, 2 << (p + 5));
			chk(hi, (2 << (p + 5)) - 32);
			meas(1);
			chk(per, 6);
		end
		wr(OFS_RUN, 8'h87);
		wr(OFS_CMP_LO, 8'h40);
		meas(2);
		meas(2);
		chk(hi, 384);
		// Light sleep freezes the pair unless the operate bit is set
		@(posedge clk);
		light_sleep_state <= 1'b1;
		wr(OFS_RUN, 8'h00);
		wr(OFS_RUN, 8'h05);
		repeat (10) @(posedge clk);
		rd(OFS_CNT_LO, 8'h00);
		wr(OFS_RUN, 8'h0d);
		repeat (10) @(posedge clk);
		rd(OFS_CNT_LO, 8'h05);
		finish_test();
	end

	// Watchdog: tests need about a third of a millisecond
	initial begin
		#2000000;
		miscompares++;
		finish_test();
	end
endmodule // tb_top

bind pbtm_timer_pair pbtm_assertions i_chk (
	.clk             (clk),
	.arst_n          (arst_n),
	.bus_req         (bus_req),
	.bus_rdata_q     (bus_rdata_q),
	.timer_out_pin   (timer_out_pin),
	.lower_match_irq (lower_match_irq),
	.upper_match_irq (upper_match_irq)
);
